// ---- design/ucil_pkg.sv ----
package ucil_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int LVL_W = 7;
  localparam int TMO_W = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_SRC = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_LCR = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_CFG = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_LSR = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_MSR = 4'h6;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_FIFO_EN = 0;
  localparam int CFG_ENH = 1;
  localparam int CFG_AUTO_CTS = 2;
  localparam int CFG_AUTO_RTS = 3;
  localparam int CFG_PIN_SEL = 4;
  localparam int CFG_RS485 = 5;
  localparam int MSK_RX = 0;
  localparam int MSK_TX = 1;
  localparam int MSK_LS = 2;
  localparam int MSK_MS = 3;
  localparam int MSK_XOFF = 5;
  localparam int MSK_RTS = 6;
  localparam int MSK_CTS = 7;
  localparam logic [7:0] MASK_BASE = 8'h0F;
  localparam logic [7:0] MASK_ENH = 8'hE0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [5:0] CFG_RST = 6'h00;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [1:0] FIFO_ON_BITS = 2'h3;

  // ----------------------------------------------------------------
  // Source codes, bits 5..0
  // ----------------------------------------------------------------
  localparam logic [5:0] SRC_LS = 6'h06;
  localparam logic [5:0] SRC_RX = 6'h04;
  localparam logic [5:0] SRC_TMO = 6'h0C;
  localparam logic [5:0] SRC_TX = 6'h02;
  localparam logic [5:0] SRC_MS = 6'h00;
  localparam logic [5:0] SRC_FLOW = 6'h10;
  localparam logic [5:0] SRC_PIN = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;

  // ----------------------------------------------------------------
  // Receive timeout: chars times (word + start + stop) plus extra bits
  // ----------------------------------------------------------------
  localparam int TMO_CHARS = 4;
  localparam int TMO_EXTRA_BITS = 12;
  localparam int WORD_BASE_BITS = 5;
  localparam int FRAME_BITS = 2;

endpackage

// ---- design/ucil_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module ucil_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // A change counts only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end

endmodule

`default_nettype wire

// ---- design/ucil_rx_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

module ucil_rx_timer
  import ucil_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic bit_tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [TMO_W-1:0] limit,
  output logic expired
);

  logic [TMO_W-1:0] cnt_r;

  // Counts bit times of silence; any receive activity starts it over
  always_ff @(posedge clk) begin
    if (reset || restart || !run) begin
      cnt_r <= '0;
    end else if (bit_tick && !expired) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || restart || !run) begin
      expired <= 1'b0;
    end else if (bit_tick && cnt_r == limit - 6'h01) begin
      expired <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- design/ucil_top.sv ----
//
// Functional notes
// - FIFO receive interrupt follows trigger level
// - Data ready set on push, cleared empty
// - Status bits 5/6 show transmit emptiness
// - Overrun, head error type, any-FIFO error
// - Mask bit 7 enables CTS rise interrupt
// - Mask bit 6 enables RTS rise interrupt
// - Mask bits 7..5 need enhanced enable
// - Modem interrupt on any delta bit
// - Line interrupt on error, again at head
// - Head error flags only at head
// - Transmit interrupt at trigger and empty
// - Non-FIFO receive and transmit interrupts
// - Source register reports highest priority only
// - Timeout timer, cleared by data read
// - Flow/special characters interrupt, read clears
// - Pin change interrupts under auto flow
// - Wake indication cleared by global read
// - Each source clears on its access
// - Priority codes one to seven
// - Source bits 7:6 show FIFO enable
// - Source bit 0 low when pending
// - Timeout is four chars plus twelve bits
//
`timescale 1ns/10ps
`default_nettype none

module ucil_top
  import ucil_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] rx_trigger,
  input wire logic [LVL_W-1:0] tx_level,
  input wire logic [LVL_W-1:0] tx_trigger,
  input wire logic tsr_empty,
  input wire logic rx_push,
  input wire logic rx_push_err,
  input wire logic overrun_event,
  input wire logic [2:0] head_err,
  input wire logic fifo_err_any,
  input wire logic [7:0] rx_head_data,
  input wire logic bit_tick,
  input wire logic [3:0] msr_lines,
  input wire logic [3:0] msr_change,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  input wire logic rts_level,
  input wire logic dtr_level,
  input wire logic xon_det,
  input wire logic xoff_det,
  input wire logic special_det,
  input wire logic sleep_exit,
  input wire logic word0_read,
  output logic rx_pop,
  output logic tx_push,
  output logic [7:0] tx_data,
  output logic irq,
  output logic wake_ind
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [TMO_W-1:0] tmo_limit(input logic [1:0] wl);
    int bits;
    bits = TMO_CHARS * (WORD_BASE_BITS + int'(wl) + FRAME_BITS);
    tmo_limit = TMO_W'(bits + TMO_EXTRA_BITS);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] mask_r;
  logic [5:0] cfg_r;
  logic [7:0] lcr_r;
  logic [7:0] isr_r;
  logic [3:0] delta_r;
  logic ls_flag_r;
  logic overrun_r;
  logic tx_flag_r;
  logic flow_flag_r;
  logic spec_flag_r;
  logic pin_flag_r;
  logic tx_below_d_r;
  logic tx_empty_d_r;
  logic pop_d_r;
  logic rts_d_r;
  logic dtr_d_r;
  logic cts_d_r;
  logic dsr_d_r;
  logic cts_sync;
  logic dsr_sync;
  logic tmo_expired;

  logic fifo_en;
  logic rd_data;
  logic rd_src;
  logic rd_lsr;
  logic rd_msr;
  logic wr_data;
  logic data_ready;
  logic tx_empty_cond;
  logic tx_below;
  logic tx_set;
  logic rx_cond;
  logic p_ls;
  logic p_rx;
  logic p_tmo;
  logic p_tx;
  logic p_ms;
  logic p_flow;
  logic p_pin;
  logic [5:0] code_nxt;
  logic [7:0] lsr_val;
  logic [7:0] rdata_nxt;
  logic flow_raise;
  logic in_rise;
  logic out_rise;

  assign fifo_en = cfg_r[CFG_FIFO_EN];
  assign rd_data = rd_en && hit(addr, OFF_DATA);
  assign rd_src = rd_en && hit(addr, OFF_SRC);
  assign rd_lsr = rd_en && hit(addr, OFF_LSR);
  assign rd_msr = rd_en && hit(addr, OFF_MSR);
  assign wr_data = wr_en && hit(addr, OFF_DATA);

  // ----------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------
  ucil_pin_sync u_cts_sync (
    .clk(clk),
    .reset(reset),
    .pin(cts_pin),
    .level(cts_sync)
  );

  ucil_pin_sync u_dsr_sync (
    .clk(clk),
    .reset(reset),
    .pin(dsr_pin),
    .level(dsr_sync)
  );

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r <= MASK_RST;
    end else if (wr_en && hit(addr, OFF_MASK)) begin
      if (cfg_r[CFG_ENH]) begin
        mask_r <= wdata & (MASK_BASE | MASK_ENH);
      end else begin
        mask_r <= (wdata & MASK_BASE) | (mask_r & MASK_ENH);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r <= CFG_RST;
    end else if (wr_en && hit(addr, OFF_CFG)) begin
      cfg_r <= wdata[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lcr_r <= LCR_RST;
    end else if (wr_en && hit(addr, OFF_LCR)) begin
      lcr_r <= wdata;
    end
  end

  // Data port: reads pop the receive head, writes push transmit data
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_pop <= 1'b0;
      tx_push <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      rx_pop <= rd_data && data_ready;
      tx_push <= wr_data;
      if (wr_data) begin
        tx_data <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line status
  // ----------------------------------------------------------------
  // level nonzero
  assign data_ready = (rx_level != '0);

  always_comb begin
    lsr_val = 8'h00;
    lsr_val[0] = data_ready;
    lsr_val[1] = overrun_r;
    lsr_val[4:2] = data_ready ? head_err : 3'h0;
    lsr_val[5] = (tx_level == '0);
    lsr_val[6] = (tx_level == '0) && tsr_empty;
    lsr_val[7] = fifo_en && fifo_err_any;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      overrun_r <= 1'b0;
    end else if (overrun_event) begin
      overrun_r <= 1'b1;
    end else if (rd_lsr) begin
      overrun_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pop_d_r <= 1'b0;
    end else begin
      pop_d_r <= rx_pop;
    end
  end

  // Head status is valid one cycle after the pop reaches the FIFO
  always_ff @(posedge clk) begin
    if (reset) begin
      ls_flag_r <= 1'b0;
    end else if ((rx_push && rx_push_err) || overrun_event ||
                 (pop_d_r && data_ready && head_err != 3'h0)) begin
      ls_flag_r <= 1'b1;
    end else if (rd_lsr) begin
      ls_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive ready and timeout
  // ----------------------------------------------------------------
  // trigger level compare
  assign rx_cond = fifo_en ? (rx_level >= rx_trigger) : data_ready;

  ucil_rx_timer u_rx_timer (
    .clk(clk),
    .reset(reset),
    .bit_tick(bit_tick),
    .run(fifo_en && data_ready),
    .restart(rx_push || rd_data),
    .limit(tmo_limit(lcr_r[1:0])),
    .expired(tmo_expired)
  );

  // ----------------------------------------------------------------
  // Transmit ready
  // ----------------------------------------------------------------
  // second issue waits for shifter
  assign tx_empty_cond = (fifo_en && cfg_r[CFG_RS485]) ?
                         ((tx_level == '0) && tsr_empty) : (tx_level == '0);
  assign tx_below = tx_level < tx_trigger;
  assign tx_set = (tx_empty_cond && !tx_empty_d_r) ||
                  (fifo_en && tx_below && !tx_below_d_r);

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_below_d_r <= 1'b1;
      tx_empty_d_r <= 1'b1;
    end else begin
      tx_below_d_r <= tx_below;
      tx_empty_d_r <= tx_empty_cond;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_flag_r <= 1'b0;
    end else if (tx_set) begin
      tx_flag_r <= 1'b1;
    end else if ((rd_src && isr_r[5:0] == SRC_TX) || wr_data) begin
      tx_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Modem status deltas and pin changes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      delta_r <= 4'h0;
    end else begin
      delta_r <= (rd_msr ? 4'h0 : delta_r) | msr_change;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rts_d_r <= 1'b1;
      dtr_d_r <= 1'b1;
      cts_d_r <= 1'b1;
      dsr_d_r <= 1'b1;
    end else begin
      rts_d_r <= rts_level;
      dtr_d_r <= dtr_level;
      cts_d_r <= cts_sync;
      dsr_d_r <= dsr_sync;
    end
  end

  // Pair select picks CTS/RTS or DSR/DTR
  assign in_rise = cfg_r[CFG_PIN_SEL] ? (dsr_sync && !dsr_d_r) : (cts_sync && !cts_d_r);
  assign out_rise = cfg_r[CFG_PIN_SEL] ? (dtr_level && !dtr_d_r) :
                    (rts_level && !rts_d_r);

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_flag_r <= 1'b0;
    end else if ((in_rise && mask_r[MSK_CTS] && cfg_r[CFG_AUTO_CTS]) ||
                 (out_rise && mask_r[MSK_RTS] && cfg_r[CFG_AUTO_RTS])) begin
      pin_flag_r <= 1'b1;
    end else if (rd_msr) begin
      pin_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flow control and special characters
  // ----------------------------------------------------------------
  assign flow_raise = mask_r[MSK_XOFF];

  always_ff @(posedge clk) begin
    if (reset) begin
      flow_flag_r <= 1'b0;
    end else if (flow_raise && (xon_det || xoff_det)) begin
      flow_flag_r <= 1'b1;
    end else if (rd_src && isr_r[5:0] == SRC_FLOW) begin
      flow_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      spec_flag_r <= 1'b0;
    // special also cleared by next char
    end else if (flow_raise && special_det) begin
      spec_flag_r <= 1'b1;
    end else if ((rd_src && isr_r[5:0] == SRC_FLOW) || rx_push) begin
      spec_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wake indication
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_ind <= 1'b0;
    end else if (sleep_exit) begin
      wake_ind <= 1'b1;
    end else if (word0_read) begin
      wake_ind <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Prioritised source
  // ----------------------------------------------------------------
  assign p_ls = ls_flag_r && mask_r[MSK_LS];
  assign p_rx = rx_cond && mask_r[MSK_RX];
  assign p_tmo = tmo_expired && mask_r[MSK_RX];
  assign p_tx = tx_flag_r && mask_r[MSK_TX];
  assign p_ms = (delta_r != 4'h0) && mask_r[MSK_MS];
  assign p_flow = flow_flag_r || spec_flag_r;
  assign p_pin = pin_flag_r;

  always_comb begin
    if (p_ls) begin
      code_nxt = SRC_LS;
    end else if (p_rx) begin
      code_nxt = SRC_RX;
    end else if (p_tmo) begin
      code_nxt = SRC_TMO;
    end else if (p_tx) begin
      code_nxt = SRC_TX;
    end else if (p_ms) begin
      code_nxt = SRC_MS;
    end else if (p_flow) begin
      code_nxt = SRC_FLOW;
    end else if (p_pin) begin
      code_nxt = SRC_PIN;
    end else begin
      code_nxt = SRC_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      isr_r <= {2'h0, SRC_NONE};
    end else begin
      isr_r <= {fifo_en ? FIFO_ON_BITS : 2'h0, code_nxt};
    end
  end

  // Request follows the registered source, so it lags events one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= (code_nxt != SRC_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (!rd_en) begin
      rdata_nxt = 8'h00;
    end else if (hit(addr, OFF_DATA)) begin
      rdata_nxt = rx_head_data;
    end else if (hit(addr, OFF_MASK)) begin
      rdata_nxt = mask_r;
    end else if (hit(addr, OFF_SRC)) begin
      rdata_nxt = isr_r;
    end else if (hit(addr, OFF_LCR)) begin
      rdata_nxt = lcr_r;
    end else if (hit(addr, OFF_CFG)) begin
      rdata_nxt = {2'h0, cfg_r};
    end else if (hit(addr, OFF_LSR)) begin
      rdata_nxt = lsr_val;
    end else if (hit(addr, OFF_MSR)) begin
      rdata_nxt = {msr_lines, delta_r};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- sim/ucil_top_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module ucil_top_chk
  import ucil_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] tx_level,
  input wire logic tsr_empty,
  input wire logic [3:0] msr_lines,
  input wire logic sleep_exit,
  input wire logic word0_read,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic [7:0] tx_data,
  input wire logic irq,
  input wire logic wake_ind
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Register reads and data port writes
  // ----------------------------------------------------------------
  sequence rd_of(logic [ADDR_W-1:0] a);
    rd_en && addr == a;
  endsequence
  src_pending_a: assert property (rd_of(OFF_SRC) |=> rdata[0] == !$past(irq))
    else $error("source bit 0 disagrees with irq");
  lsr_ready_a: assert property (rd_of(OFF_LSR) |=> rdata[0] == ($past(rx_level) != 0))
    else $error("data ready flag wrong");
  lsr_tx_a: assert property (rd_of(OFF_LSR) |=> rdata[6:5] ==
    {$past(tx_level) == 0 && $past(tsr_empty), $past(tx_level) == 0})
    else $error("transmit empty flags wrong");
  msr_lines_a: assert property (rd_of(OFF_MSR) |=> rdata[7:4] == $past(msr_lines))
    else $error("modem line states wrong");
  pop_read_a: assert property (rd_of(OFF_DATA) ##0 rx_level != 0 |=> rx_pop)
    else $error("data read did not pop");
  pop_cause_a: assert property (rx_pop |-> $past(rd_en) && $past(addr) == OFF_DATA)
    else $error("pop without data read");
  tx_write_a: assert property (wr_en && addr == OFF_DATA |=> tx_push &&
    tx_data == $past(wdata))
    else $error("data write not pushed");
  // ----------------------------------------------------------------
  // Wake indication
  // ----------------------------------------------------------------
  wake_set_a: assert property (sleep_exit |=> wake_ind)
    else $error("wake not raised");
  wake_clear_a: assert property (word0_read && !sleep_exit |=> !wake_ind)
    else $error("wake not cleared");
  wake_hold_a: assert property (wake_ind && !word0_read |=> wake_ind)
    else $error("wake dropped early");
endmodule
bind ucil_top ucil_top_chk ucil_top_chk_inst (.clk, .reset, .addr, .wdata, .wr_en, .rd_en,
  .rdata, .rx_level, .tx_level, .tsr_empty, .msr_lines, .sleep_exit, .word0_read, .rx_pop,
  .tx_push, .tx_data, .irq, .wake_ind);
`default_nettype wire

// ---- sim/ucil_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module ucil_top_tb_top import ucil_pkg::*;;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] msk;
    logic [7:0] rxl;
    logic [7:0] em;
    logic [7:0] es;
  } ucil_tbrow_t;
  logic clk, reset, wr_en, rd_en, tsr_empty, rx_push_err, fifo_err_any, cts_pin, rts_level;
  logic dsr_pin, dtr_level;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, ev, rdata, tx_data;
  logic [LVL_W-1:0] rx_level, rx_trigger, tx_level, tx_trigger;
  logic [2:0] head_err;
  logic [3:0] msr_change;
  logic rx_pop, tx_push, irq, wake_ind;
  int errors, check_count, i;
  // Mask bits 7..5 stick once set, so rows clear them with enhanced on
  ucil_tbrow_t rows [7] = '{'{8'h00, 8'hFF, 8'h00, 8'h0F, 8'h01},
    '{8'h00, 8'h01, 8'h01, 8'h01, 8'h04}, '{8'h02, 8'hFF, 8'h00, 8'hEF, 8'h01},
    '{8'h03, 8'h00, 8'h04, 8'h00, 8'hC1}, '{8'h01, 8'h01, 8'h03, 8'h01, 8'hC1},
    '{8'h01, 8'h01, 8'h04, 8'h01, 8'hC4}, '{8'h01, 8'h01, 8'h02, 8'h01, 8'hC1}};

  // Event inputs share one vector so a single pulse task serves all
  ucil_top ucil_top_inst (.clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .rx_level,
    .rx_trigger, .tx_level, .tx_trigger, .tsr_empty, .rx_push(ev[3]), .rx_push_err,
    .overrun_event(ev[6]), .head_err, .fifo_err_any, .rx_head_data(8'h5A), .bit_tick(ev[7]),
    .msr_lines(4'hA), .msr_change, .cts_pin, .dsr_pin, .rts_level, .dtr_level,
    .xon_det(ev[0]), .xoff_det(ev[1]), .special_det(ev[2]), .sleep_exit(ev[4]),
    .word0_read(ev[5]), .rx_pop, .tx_push, .tx_data, .irq, .wake_ind);

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    {wr_en, addr, wdata} <= {1'b1, a, v};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    {rd_en, addr} <= {1'b1, a};
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
  endtask
  task src(input logic [7:0] e);
    idle(3);
    rd(OFF_SRC);
    chk(rdata, e);
  endtask
  task pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    idle(20000);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {wr_en, rd_en, tsr_empty, rx_push_err, fifo_err_any, cts_pin, rts_level} = '0;
    {dsr_pin, dtr_level} = 2'b00;
    {addr, wdata, ev, head_err, msr_change, rx_level} = '0;
    {tx_level, rx_trigger, tx_trigger} = {7'h05, 7'h04, 7'h01};
    {errors, check_count} = '0;
    reset = 1'b1;
    idle(5);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) begin
      wr(OFF_CFG, rows[i].cfg);
      rx_level <= rows[i].rxl[6:0];
      wr(OFF_MASK, rows[i].msk);
      rd(OFF_MASK);
      chk(rdata, rows[i].em);
      src(rows[i].es);
      chk({7'h00, irq}, {7'h00, ~rows[i].es[0]});
    end
    done("rows");
    {rx_level, fifo_err_any, rx_push_err} <= {7'h04, 2'b11};
    // Polled use: enables 3..0 off, status still readable
    wr(OFF_MASK, 8'h00);
    rd(OFF_LSR);
    chk(rdata, 8'h81);
    src(8'hC1);
    wr(OFF_MASK, 8'h0F);
    pulse(3);
    rx_push_err <= 1'b0;
    src(8'hC6);
    rd(OFF_LSR);
    chk(rdata, 8'h81);
    src(8'hC4);
    head_err <= 3'b001;
    rd(OFF_DATA);
    chk(rdata, 8'h5A);
    src(8'hC6);
    rd(OFF_LSR);
    chk(rdata, 8'h85);
    {head_err, fifo_err_any, rx_level} <= '0;
    pulse(6);
    src(8'hC6);
    rd(OFF_LSR);
    chk(rdata, 8'h02);
    src(8'hC1);
    done("line status");
    wr(OFF_MASK, 8'h02);
    tx_level <= 7'h00;
    src(8'hC2);
    src(8'hC1);
    {tx_trigger, tx_level} <= {7'h08, 7'h0A};
    idle(3);
    tx_level <= 7'h07;
    src(8'hC2);
    wr(OFF_DATA, 8'h3C);
    src(8'hC1);
    tx_level <= 7'h00;
    src(8'hC2);
    src(8'hC1);
    {tx_trigger, tx_level} <= {7'h00, 7'h03};
    idle(3);
    wr(OFF_CFG, 8'h21);
    tx_level <= 7'h00;
    src(8'hC1);
    tsr_empty <= 1'b1;
    src(8'hC2);
    src(8'hC1);
    tx_level <= 7'h05;
    done("transmit");
    wr(OFF_MASK, 8'h08);
    msr_change <= 4'h2;
    @(posedge clk);
    msr_change <= 4'h0;
    src(8'hC0);
    rd(OFF_MSR);
    chk(rdata, 8'hA2);
    src(8'hC1);
    done("modem");
    // Pins pass a synchroniser, so each edge gets a few cycles to land
    wr(OFF_CFG, 8'h0B);
    wr(OFF_MASK, 8'hC0);
    cts_pin <= 1'b1;
    idle(4);
    src(8'hC1);
    cts_pin <= 1'b0;
    idle(4);
    wr(OFF_CFG, 8'h0F);
    cts_pin <= 1'b1;
    idle(4);
    src(8'hE0);
    rd(OFF_MSR);
    src(8'hC1);
    rts_level <= 1'b1;
    src(8'hE0);
    rd(OFF_MSR);
    src(8'hC1);
    // Switch to the DSR/DTR pair; the switch itself must not count as a change
    wr(OFF_CFG, 8'h1F);
    src(8'hC1);
    dsr_pin <= 1'b1;
    idle(4);
    src(8'hE0);
    rd(OFF_MSR);
    dtr_level <= 1'b1;
    src(8'hE0);
    rd(OFF_MSR);
    src(8'hC1);
    done("pin change");
    wr(OFF_MASK, 8'h20);
    for (i = 0; i < 3; i++) begin
      pulse(i);
      src(8'hD0);
      src(8'hC1);
    end
    pulse(2);
    pulse(3);
    src(8'hC1);
    done("flow");
    wr(OFF_CFG, 8'h01);
    wr(OFF_MASK, 8'h01);
    wr(OFF_LCR, 8'h03);
    rx_level <= 7'h01;
    pulse(3);
    for (i = 0; i < 4 * (WORD_BASE_BITS + 3 + FRAME_BITS) + 11; i++) begin
      pulse(7);
    end
    src(8'hC1);
    pulse(7);
    src(8'hCC);
    rd(OFF_DATA);
    src(8'hC1);
    done("timeout");
    pulse(4);
    #1;
    chk({7'h00, wake_ind}, 8'h01);
    pulse(5);
    #1;
    chk({7'h00, wake_ind}, 8'h00);
    rd(4'hF);
    chk(rdata, 8'h00);
    done("wake and unmapped");
    wr(OFF_MASK, 8'h0F);
    reset <= 1'b1;
    idle(5);
    reset <= 1'b0;
    rd(OFF_MASK);
    chk(rdata, 8'h00);
    src(8'h01);
    chk({7'h00, irq}, 8'h00);
    done("reset");
    report_and_stop();
  end
endmodule
`default_nettype wire
